// File: dmc_bus_master.sv
/*
  Bus request, bus master strobes, command intake, status read
  sequence and interrupt chain of a DMA controller.
  Assumes all pins are synchronous to REF_CLK and that open-drain
  and two-way wires are resolved outside from the enables.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Master address drives both ports
// - Grant input hands over the buses
// - Pass grant only when not requesting
// - Withhold request while another requests
// - Selected host write delivers command byte
// - Wait input stretches master cycles
// - Chain out follows chain in unless in service
// - Open-drain interrupt, fetch-cycle acknowledge
// - Pulse mode only while bus master
// - Slave select needs select, strobe, io
// - Port cycles signal valid port address
// - Fetch plus io request means acknowledge
// - Return-from-interrupt pair ends service
// - Memory request marks memory transfer
// - Read strobe two ways
// - Write strobe two ways
// - Ready polarity selectable, paces requests
// - Reset forces disabled state
// - Any write disables until enable
// - Base byte pointers order following bytes
// - Group zero loads address low, high
// - Status reads follow masked fixed order
module dmc_bus_master
  import dmc_pkg::*;
#(
  parameter logic [7:0] VECTOR = 8'h00 // Arbitrary vector value
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Host side
  input wire logic SELECT_WAIT_N,
  input wire logic IO_REQUEST_N_I,
  input wire logic RD_N_I,
  input wire logic WR_N_I,
  input wire logic OPCODE_FETCH_CYCLE_N,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE,
  // Bus master side
  output logic [15:0] ADDR_O,
  output logic ADDR_OE,
  output dmc_ctl_t CTL_O,
  output logic CTL_OE,
  input wire logic PERIPH_READY,
  // Bus arbitration
  input wire logic GRANT_CHAIN_IN_N,
  output logic GRANT_CHAIN_OUT_N,
  input wire logic BUS_REQUEST_LINE_I,
  output logic BUS_REQUEST_LINE_O,
  output logic BUS_REQUEST_LINE_OE,
  // Interrupt chain
  input wire logic IRQ_CHAIN_IN,
  output logic IRQ_CHAIN_OUT,
  output logic IRQ_N_O,
  output logic IRQ_N_OE
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // First set bit at or above a start index, with a found flag
  function automatic logic [3:0] first_at(input logic [7:0] m,
                                          input logic [2:0] from);
    logic [3:0] r;
    r = '0;
    for (int i = 7; i >= 0; i--)
    begin
      if (m[i] && (3'(i) >= from))
      begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  dmc_state_t state;
  dmc_cfg_t cfg;
  logic enabled;
  logic [15:0] addr_a;
  logic [15:0] len;
  logic [7:0] port_b;
  logic [7:0] xfer;
  logic [4:0] pend;
  logic mask_pend;
  logic [6:0] rd_mask;
  logic [2:0] rd_ptr;
  logic rd_valid;
  logic irq_pend;
  logic in_service;
  logic pulse;
  logic prev_sel_wr;
  logic prev_sel_rd;
  logic prev_fetch;
  logic [7:0] opbyte;
  logic ed_seen;
  logic [3:0] slot;
  logic [3:0] nxt_rd;
  logic [3:0] first_rd;
  logic [7:0] rd_byte;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Host access and cycle qualifiers
  logic bus_master;
  logic req_active;
  logic sel_wr;
  logic sel_rd;
  logic wr_take;
  logic rd_end;
  logic int_ack;
  logic fetch;
  logic fetch_end;
  logic return_from_interrupt;
  logic rdy_act;
  logic stretch;
  logic byte_done;
  logic is_cmd;
  assign bus_master = (state == ST_RD) || (state == ST_WR);
  assign req_active = (state == ST_REQ) || bus_master;
  assign sel_wr = !SELECT_WAIT_N && !IO_REQUEST_N_I && !WR_N_I
                  && !bus_master;
  assign sel_rd = !SELECT_WAIT_N && !IO_REQUEST_N_I && !RD_N_I
                  && OPCODE_FETCH_CYCLE_N && !bus_master;
  assign wr_take = sel_wr && !prev_sel_wr;
  assign rd_end = prev_sel_rd && !sel_rd;
  assign int_ack = !OPCODE_FETCH_CYCLE_N && !IO_REQUEST_N_I;
  assign fetch = !OPCODE_FETCH_CYCLE_N && !RD_N_I;
  assign fetch_end = prev_fetch && !fetch;
  assign return_from_interrupt = fetch_end && ed_seen && (opbyte == RETURN_FROM_INTERRUPT_SECOND);
  assign rdy_act = (PERIPH_READY == cfg.rdy_pol);
  assign stretch = cfg.wait_en && !SELECT_WAIT_N;
  assign byte_done = (state == ST_WR) && !stretch;
  assign is_cmd = DATA_I[BIT_GROUP] && (DATA_I[1:0] == ID_CMD);
  assign slot = first_at({3'h0, pend}, 3'h0);
  assign nxt_rd = first_at({1'b0, rd_mask}, 3'(rd_ptr + 3'h1));
  assign first_rd = first_at({1'b0, rd_mask}, 3'h0);

  // Edge history of host strobes
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      prev_sel_wr <= 1'b0;
      prev_sel_rd <= 1'b0;
      prev_fetch <= 1'b0;
    end
    else
    begin
      prev_sel_wr <= sel_wr;
      prev_sel_rd <= sel_rd;
      prev_fetch <= fetch;
    end
  end

  // ---------------------------------------------------------------
  // Enable and configuration
  // ---------------------------------------------------------------
  // Any written byte disables; only the enable command enables
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      enabled <= 1'b0;
    end
    else if (wr_take)
    begin
      enabled <= (pend == '0) && !mask_pend
                 && (DATA_I == CMD_ENABLE);
    end
  end

  // Configuration byte, wait function off after reset
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      cfg <= '0;
    end
    else if (wr_take && pend == '0 && !mask_pend)
    begin
      if (DATA_I[BIT_GROUP] && !DATA_I[0])
      begin
        cfg <= dmc_cfg_t'(DATA_I[PTR_MSB:CFG_LSB]);
      end
      else if (DATA_I == CMD_RESET)
      begin
        cfg <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write register groups and transfer counters
  // ---------------------------------------------------------------
  // Base byte loads pointers; following bytes fill them in order
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pend <= '0;
      mask_pend <= 1'b0;
      addr_a <= '0;
      len <= '0;
      port_b <= '0;
    end
    else if (wr_take)
    begin
      if (pend != '0)
      begin
        pend[slot[2:0]] <= 1'b0;
        case (slot[2:0])
          3'h0: addr_a[7:0] <= DATA_I;
          3'h1: addr_a[15:8] <= DATA_I;
          3'h2: len[7:0] <= DATA_I;
          3'h3: len[15:8] <= DATA_I;
          default: port_b <= DATA_I;
        endcase
      end
      else if (mask_pend)
      begin
        mask_pend <= 1'b0;
      end
      else if (!DATA_I[BIT_GROUP] && DATA_I[1:0] != 2'h0)
      begin
        pend <= DATA_I[PTR_MSB:PTR_LSB];
      end
      else if (is_cmd)
      begin
        mask_pend <= (DATA_I == CMD_READ_MASK);
      end
    end
    else if (byte_done)
    begin
      addr_a <= addr_a + 16'h0001;
      len <= len - 16'h0001;
    end
  end

  // Captured byte between memory read and port write
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      xfer <= '0;
    end
    else if (state == ST_RD && !stretch && rdy_act)
    begin
      xfer <= DATA_I;
    end
  end

  // ---------------------------------------------------------------
  // Status read sequence
  // ---------------------------------------------------------------
  // Mask and pointer of the fixed-order status reads
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      rd_mask <= MASK_RESET;
      rd_ptr <= '0;
      rd_valid <= 1'b0;
    end
    else if (wr_take && mask_pend && pend == '0)
    begin
      rd_mask <= DATA_I[6:0];
    end
    else if (wr_take && pend == '0 && DATA_I == CMD_INIT_READ)
    begin
      rd_ptr <= first_rd[2:0];
      rd_valid <= (rd_mask != '0);
    end
    else if (wr_take && pend == '0 && DATA_I == CMD_READ_STATUS)
    begin
      rd_ptr <= '0;
      rd_valid <= 1'b1;
    end
    else if (wr_take && pend == '0 && DATA_I == CMD_RESET)
    begin
      rd_valid <= 1'b0;
    end
    else if (rd_end && rd_valid)
    begin
      rd_ptr <= nxt_rd[2:0];
      rd_valid <= nxt_rd[3];
    end
  end

  // Byte selected by the read pointer
  always_comb
  begin
    case (rd_ptr)
      3'h0: rd_byte = {3'h0, in_service, irq_pend, bus_master,
                       (len != '0), enabled};
      3'h1: rd_byte = len[7:0];
      3'h2: rd_byte = len[15:8];
      3'h3: rd_byte = addr_a[7:0];
      3'h4: rd_byte = addr_a[15:8];
      3'h5: rd_byte = port_b;
      default: rd_byte = {2'h0, cfg};
    endcase
  end

  // Registered data bus drive
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      DATA_O <= '0;
      DATA_OE <= 1'b0;
    end
    else if (state == ST_RD && !stretch && rdy_act)
    begin
      DATA_O <= DATA_I; // Byte stands from the first write cycle
      DATA_OE <= 1'b1;
    end
    else if (state == ST_WR && stretch)
    begin
      DATA_O <= xfer;
      DATA_OE <= 1'b1;
    end
    else if (int_ack && irq_pend && IRQ_CHAIN_IN)
    begin
      DATA_O <= VECTOR;
      DATA_OE <= 1'b1;
    end
    else
    begin
      DATA_O <= rd_byte;
      DATA_OE <= sel_rd && rd_valid;
    end
  end

  // ---------------------------------------------------------------
  // Bus ownership sequencer
  // ---------------------------------------------------------------
  // Request, grant, read-write byte cycles, release
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (enabled && rdy_act && len != '0 && BUS_REQUEST_LINE_I)
          begin
            state <= ST_REQ;
          end
        end
        ST_REQ:
        begin
          if (!enabled)
          begin
            state <= ST_REL;
          end
          else if (!GRANT_CHAIN_IN_N)
          begin
            state <= ST_RD;
          end
        end
        ST_RD:
        begin
          if (!stretch && rdy_act)
          begin
            state <= ST_WR;
          end
        end
        ST_WR:
        begin
          if (!stretch)
          begin
            if (len == 16'h0001 || cfg.mode == MODE_BYTE)
            begin
              state <= ST_REL;
            end
            else if (cfg.mode == MODE_BURST && !rdy_act)
            begin
              state <= ST_REL;
            end
            else
            begin
              state <= ST_RD;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Master strobes and address
  always_comb
  begin
    CTL_O = '1;
    CTL_O.memory_request_n = (state != ST_RD);
    CTL_O.rd_n = (state != ST_RD);
    CTL_O.io_request_n = (state != ST_WR);
    CTL_O.wr_n = (state != ST_WR);
    ADDR_O = (state == ST_WR) ? {IO_HI, port_b} : addr_a;
  end
  assign CTL_OE = bus_master;
  assign ADDR_OE = bus_master;

  // Arbitration chain and open-drain request
  assign GRANT_CHAIN_OUT_N = GRANT_CHAIN_IN_N || req_active;
  assign BUS_REQUEST_LINE_O = 1'b0;
  assign BUS_REQUEST_LINE_OE = req_active;

  // ---------------------------------------------------------------
  // Interrupt logic
  // ---------------------------------------------------------------
  // Pending, in-service and return-from-interrupt tracking
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      irq_pend <= 1'b0;
      in_service <= 1'b0;
      opbyte <= '0;
      ed_seen <= 1'b0;
    end
    else
    begin
      if (byte_done && len == 16'h0001 && cfg.irq_en)
      begin
        irq_pend <= 1'b1;
      end
      else if ((int_ack && IRQ_CHAIN_IN)
               || (wr_take && pend == '0 && DATA_I == CMD_RESET))
      begin
        irq_pend <= 1'b0;
      end
      if (int_ack && irq_pend && IRQ_CHAIN_IN)
      begin
        in_service <= 1'b1;
      end
      else if (return_from_interrupt)
      begin
        in_service <= 1'b0;
      end
      if (fetch)
      begin
        opbyte <= DATA_I;
      end
      if (fetch_end)
      begin
        ed_seen <= (opbyte == RETURN_FROM_INTERRUPT_FIRST);
      end
    end
  end

  // Open-drain interrupt or one pulse per byte after which mastership is kept
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      pulse <= 1'b0;
    end
    else if (cfg.pulse_en)
    begin
      pulse <= byte_done;
    end
    else
    begin
      pulse <= irq_pend && IRQ_CHAIN_IN && !in_service;
    end
  end
  assign IRQ_N_O = 1'b0;
  assign IRQ_N_OE = pulse && (!cfg.pulse_en || bus_master);
  assign IRQ_CHAIN_OUT = IRQ_CHAIN_IN && !in_service;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_grant;
    state == ST_REQ ##0 enabled && !GRANT_CHAIN_IN_N;
  endsequence
  sequence s_return_from_interrupt;
    fetch_end && opbyte == RETURN_FROM_INTERRUPT_FIRST ##[1:20] fetch_end && ed_seen
      && opbyte == RETURN_FROM_INTERRUPT_SECOND;
  endsequence

  AST_GRANT_TAKE: assert property (s_grant |=> state == ST_RD)
    else $error("grant not taken");
  AST_GRANT_PASS: assert property (!GRANT_CHAIN_OUT_N |->
    !req_active && !GRANT_CHAIN_IN_N)
    else $error("grant passed while requesting");
  AST_REQ_HOLD: assert property (state == ST_IDLE
    && !BUS_REQUEST_LINE_I |=> !BUS_REQUEST_LINE_OE)
    else $error("request during foreign request");
  AST_WAIT_STRETCH: assert property (state == ST_RD && stretch
    |=> state == ST_RD && !CTL_O.rd_n)
    else $error("wait not honoured");
  AST_CHAIN_BLOCK: assert property (in_service |-> !IRQ_CHAIN_OUT)
    else $error("chain not blocked");
  AST_PULSE_MASTER: assert property (IRQ_N_OE && cfg.pulse_en
    |-> bus_master)
    else $error("pulse outside mastership");
  AST_SLAVE_SEL: assert property (bus_master |-> !sel_wr && !sel_rd)
    else $error("slave select while master");
  AST_IO_CYCLE: assert property (state == ST_WR |-> !CTL_O.io_request_n
    && ADDR_O[15:8] == IO_HI && CTL_O.memory_request_n)
    else $error("bad port cycle");
  AST_ACK: assert property (int_ack && irq_pend && IRQ_CHAIN_IN
    |=> in_service && !irq_pend)
    else $error("acknowledge missed");
  AST_RETURN_FROM_INTERRUPT: assert property (s_return_from_interrupt |=> !in_service)
    else $error("service not ended");
  AST_MEM_CYCLE: assert property (state == ST_RD |-> ADDR_O == addr_a
    && !CTL_O.memory_request_n && CTL_OE)
    else $error("bad memory cycle");
  AST_DISABLE: assert property (wr_take && DATA_I != CMD_ENABLE
    |=> !enabled)
    else $error("write left block enabled");
  AST_PTR_LOW: assert property (wr_take && pend[0]
    |=> !pend[0] && addr_a[7:0] == $past(DATA_I))
    else $error("pointer order broken");
endmodule // dmc_bus_master

// File: dmc_bus_master_tb.sv
/*
  Self-checking bench for the bus master controller: programming,
  status reads, transfers, arbitration and interrupt chain.
  Assumes dmc_pkg and dmc_bus_partner are compiled first.
*/
`timescale 1ns/10ps
module dmc_bus_master_tb
  import dmc_pkg::*;
;
  localparam logic [7:0] VEC = 8'h5e; // Arbitrary vector value
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic sel_n, h_io_n, h_rd_n, h_wr_n, fetch_n, ready, chain_in, other_req;
  logic [7:0] h_data, data_w, data_o, mem_data;
  logic data_oe, addr_oe, ctl_oe, gout_n, breq_o, breq_oe, irq_out, irq_o, irq_oe;
  logic grant_n, mem_oe, rd_w, wr_w, io_w, breq_w, in_rd, in_wr;
  logic [15:0] addr_o, cur, rd_addr;
  logic [3:0] lag;
  dmc_ctl_t ctl_o;
  logic [31:0] seed = 32'h6363;
  int n_errors, compares, cyc, nbytes, len, npulse;
  logic [7:0] portb;
  int exp_q[$];

  // ---------------------------------------------------------------
  // Wires and instances
  // ---------------------------------------------------------------
  // Shared wires resolved from every driver
  assign rd_w = ctl_oe ? ctl_o.rd_n : h_rd_n;
  assign wr_w = ctl_oe ? ctl_o.wr_n : h_wr_n;
  assign io_w = ctl_oe ? ctl_o.io_request_n : h_io_n;
  assign breq_w = !(breq_oe || other_req);
  assign data_w = data_oe ? data_o : (mem_oe ? mem_data : h_data);

  dmc_bus_master #(.VECTOR(VEC)) uut (.REF_CLK(ref_clk), .SRST(srst),
    .SELECT_WAIT_N(sel_n), .IO_REQUEST_N_I(io_w), .RD_N_I(rd_w), .WR_N_I(wr_w),
    .OPCODE_FETCH_CYCLE_N(fetch_n), .DATA_I(data_w), .DATA_O(data_o),
    .DATA_OE(data_oe), .ADDR_O(addr_o), .ADDR_OE(addr_oe), .CTL_O(ctl_o),
    .CTL_OE(ctl_oe), .PERIPH_READY(ready), .GRANT_CHAIN_IN_N(grant_n),
    .GRANT_CHAIN_OUT_N(gout_n), .BUS_REQUEST_LINE_I(breq_w),
    .BUS_REQUEST_LINE_O(breq_o), .BUS_REQUEST_LINE_OE(breq_oe),
    .IRQ_CHAIN_IN(chain_in), .IRQ_CHAIN_OUT(irq_out), .IRQ_N_O(irq_o),
    .IRQ_N_OE(irq_oe));

  dmc_bus_partner far (.clk(ref_clk), .rst(srst), .lag(lag), .breq_n(breq_w),
    .grant_n(grant_n), .ctl(ctl_o), .ctl_oe(ctl_oe), .addr(addr_o),
    .mem_oe(mem_oe), .mem_data(mem_data));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Clock and timeout
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Host write of one byte
  task automatic hw(input logic [7:0] b);
    @(posedge ref_clk);
    sel_n <= 1'b0; h_io_n <= 1'b0; h_wr_n <= 1'b0; h_data <= b;
    repeat (2) @(posedge ref_clk);
    sel_n <= 1'b1; h_io_n <= 1'b1; h_wr_n <= 1'b1; h_data <= ~b;
    @(posedge ref_clk);
  endtask

  // Host read, optionally without io request
  task automatic hr(input logic [7:0] exp, input logic oe, input logic io_n);
    @(posedge ref_clk);
    sel_n <= 1'b0; h_io_n <= io_n; h_rd_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check(data_oe, oe);
    if (oe)
      check(data_o, exp);
    @(posedge ref_clk);
    sel_n <= 1'b1; h_io_n <= 1'b1; h_rd_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // Processor cycle with fetch marker and io or read strobe
  task automatic cpu(input logic io_n, input logic [7:0] b);
    @(posedge ref_clk);
    fetch_n <= 1'b0; h_io_n <= io_n; h_rd_n <= ~io_n; h_data <= b;
    @(posedge ref_clk);
    #1;
    if (!io_n)
      check({data_oe, data_o}, {1'b1, VEC});
    repeat (2) @(posedge ref_clk);
    fetch_n <= 1'b1; h_io_n <= 1'b1; h_rd_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // Wait for n written bytes, optionally with random wait input
  task automatic wait_bytes(input int n, input logic rnd);
    for (int i = 0; i < 400 && nbytes < n; i++)
    begin
      @(posedge ref_clk);
      if (rnd && nbytes < n)
      begin
        seed = lfsr(seed);
        sel_n <= seed[0];
      end
    end
    @(posedge ref_clk);
    sel_n <= 1'b1;
    check(nbytes, n);
  endtask

  // ---------------------------------------------------------------
  // Master cycle monitor
  // ---------------------------------------------------------------
  // Compare address, strobes and data with the model at mid-cycle
  always @(negedge ref_clk)
  begin
    if (ctl_oe && !ctl_o.memory_request_n && !ctl_o.rd_n && !in_rd)
    begin
      check(addr_o, cur);
      check(gout_n, 1'b1);
      rd_addr = cur;
      cur++;
    end
    if (ctl_oe && !ctl_o.io_request_n && !ctl_o.wr_n)
    begin
      if (!in_wr)
      begin
        check(addr_o, {IO_HI, portb});
        nbytes++;
      end
      check({data_oe, data_o}, {1'b1, rd_addr[7:0] ^ 8'h3c});
    end
    in_rd = ctl_oe && !ctl_o.rd_n;
    in_wr = ctl_oe && !ctl_o.wr_n;
    if (irq_oe)
      npulse++;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    sel_n = 1; h_io_n = 1; h_rd_n = 1; h_wr_n = 1; fetch_n = 1; h_data = 0;
    ready = 1; chain_in = 1; other_req = 0; lag = 4'h3;
    in_rd = 0; in_wr = 0;
    seed = lfsr(seed);
    cur = seed[15:0];
    seed = lfsr(seed);
    portb = seed[7:0];
    len = 1 + seed[9:8];
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    check({addr_oe, ctl_oe, data_oe, breq_oe, irq_oe, breq_o}, 6'h0);
    check(irq_out, 1'b1);
    // Program address, length and port with active-low ready
    exp_q = '{8'h02, len, 0, cur[7:0], cur[15:8], portb};
    hw(8'h7d);
    hw(cur[7:0]);
    hw(cur[15:8]);
    hw(len[7:0]);
    hw(8'h00);
    hw(portb);
    hw(8'h90);
    hw(CMD_ENABLE);
    repeat (10) @(posedge ref_clk);
    check(breq_oe, 1'b0);
    // Active-high ready, mask out the last register, read back
    hw(8'h92);
    hw(CMD_READ_MASK);
    hw(8'h3f);
    hw(CMD_INIT_READ);
    hr(8'h00, 1'b0, 1'b1);
    foreach (exp_q[i])
      hr(exp_q[i][7:0], 1'b1, 1'b0);
    hr(8'h00, 1'b0, 1'b0);
    // Another master holds the request line
    other_req <= 1'b1;
    hw(CMD_ENABLE);
    repeat (8) @(posedge ref_clk);
    check(breq_oe, 1'b0);
    other_req <= 1'b0;
    wait_bytes(len, 1'b0);
    for (int i = 0; i < 50 && !irq_oe; i++)
      @(posedge ref_clk);
    check({irq_oe, irq_o}, 2'b10);
    // Acknowledge, then return-from-interrupt pair
    cpu(1'b0, 8'h00);
    check({irq_out, irq_oe}, 2'b00);
    cpu(1'b1, RETURN_FROM_INTERRUPT_FIRST);
    check(irq_out, 1'b0);
    cpu(1'b1, RETURN_FROM_INTERRUPT_SECOND);
    #1;
    check(irq_out, 1'b1);
    chain_in <= 1'b0;
    @(posedge ref_clk);
    #1;
    check(irq_out, 1'b0);
    // Length low only, prompt grant
    lag <= 4'h0;
    hw(8'h11);
    hw(8'h01);
    hw(CMD_ENABLE);
    wait_bytes(len + 1, 1'b0);
    #1;
    check(breq_oe, 1'b0);
    // Burst of three with random wait states and master pulses
    hw(8'h11);
    hw(8'h03);
    hw(8'hae);
    hw(CMD_ENABLE);
    npulse = 0;
    wait_bytes(len + 4, 1'b1);
    repeat (4) @(posedge ref_clk);
    check(npulse, 2);
    // Reset in mid-run clears pending, configuration and registers
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    check({addr_oe, ctl_oe, data_oe, breq_oe, irq_oe}, 5'h0);
    hw(CMD_READ_STATUS);
    for (int i = 0; i < 7; i++)
      hr(8'h00, 1'b1, 1'b0);
    end_sim();
  end
endmodule // dmc_bus_master_tb

// File: dmc_bus_partner.sv
/*
  Far side model: bus arbiter of the host processor and a memory
  that answers master reads with a byte derived from the address.
  Assumes the bench resolves the open-drain request wire and
  the shared data and strobe wires from all enables.
*/
`timescale 1ns/10ps
module dmc_bus_partner
  import dmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Arbitration
  input wire logic [3:0] lag,
  input wire logic breq_n,
  output logic grant_n,
  // Memory
  input wire dmc_ctl_t ctl,
  input wire logic ctl_oe,
  input wire logic [15:0] addr,
  output logic mem_oe,
  output logic [7:0] mem_data
);
  logic [3:0] cnt;

  // ---------------------------------------------------------------
  // Arbiter
  // ---------------------------------------------------------------
  // Grant after lag cycles of a held request, withdraw on release
  always_ff @(posedge clk)
  begin
    if (rst || breq_n)
    begin
      cnt <= 4'h0;
      grant_n <= 1'b1;
    end
    else if (cnt >= lag)
      grant_n <= 1'b0;
    else
      cnt <= cnt + 4'h1;
  end

  // ---------------------------------------------------------------
  // Memory
  // ---------------------------------------------------------------
  // Drive data only during a master memory read
  assign mem_oe = ctl_oe && !ctl.memory_request_n && !ctl.rd_n;
  assign mem_data = addr[7:0] ^ 8'h3c;
endmodule // dmc_bus_partner

// File: dmc_pkg.sv
/*
  Shared constants and types for the bus master controller.
  Assumes one system clock and an 8-bit host data path.
*/
package dmc_pkg;
  // ---------------------------------------------------------------
  // Command byte decoding
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_ENABLE = 8'h87;
  localparam logic [7:0] CMD_DISABLE = 8'h83;
  localparam logic [7:0] CMD_RESET = 8'hc3;
  localparam logic [7:0] CMD_INIT_READ = 8'ha7;
  localparam logic [7:0] CMD_READ_STATUS = 8'hbf;
  localparam logic [7:0] CMD_READ_MASK = 8'hbb;
  localparam int BIT_GROUP = 7;
  localparam int PTR_LSB = 2;
  localparam int PTR_MSB = 6;
  localparam int CFG_LSB = 1;
  localparam logic [1:0] ID_CMD = 2'h3;
  // Return-from-interrupt opcode pair
  localparam logic [7:0] RETURN_FROM_INTERRUPT_FIRST = 8'hed;
  localparam logic [7:0] RETURN_FROM_INTERRUPT_SECOND = 8'h4d;
  // Upper address byte during an 8-bit port cycle
  localparam logic [7:0] IO_HI = 8'h00;
  localparam logic [6:0] MASK_RESET = 7'h7f;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_BYTE = 2'h0,
    MODE_BURST = 2'h1,
    MODE_CONT = 2'h2
  } dmc_mode_t;
  typedef struct packed {
    logic [1:0] mode;
    logic irq_en;
    logic pulse_en;
    logic wait_en;
    logic rdy_pol;
  } dmc_cfg_t;
  typedef struct packed {
    logic memory_request_n;
    logic io_request_n;
    logic rd_n;
    logic wr_n;
  } dmc_ctl_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_REQ = 5'b00010,
    ST_RD = 5'b00100,
    ST_WR = 5'b01000,
    ST_REL = 5'b10000
  } dmc_state_t;
endpackage
